// ### plebr_bridge.sv
// Bridge from PCI target accesses onto the multiplexed local bus.
`timescale 1ns/10ps
module plebr_bridge
    import plebr_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // PCI clock pin, window base and strobe style.
    input wire logic pci_clk,
    input wire logic [BASE_W-1:0] window_base,
    input wire logic strobe_mode,
    // Request from the PCI target logic.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [31:0] req_addr,
    input wire logic [3:0] req_be_n,
    input wire logic [DATA_W-1:0] req_wdata,
    // Answer to the PCI target logic.
    output logic req_ack,
    output logic req_miss,
    output logic [DATA_W-1:0] req_rdata,
    // Local bus clock.
    output logic local_bus_clock_out,
    output logic local_bus_clock_oe_n,
    // Multiplexed address and data.
    input wire logic [DATA_W-1:0] local_addr_data_in,
    output logic [DATA_W-1:0] local_addr_data_out,
    output logic local_addr_data_oe_n,
    // Strobes and lane selects.
    output logic [3:0] local_lane_select_n,
    output logic local_data_strobe_n,
    output logic local_rw_strobe,
    output logic local_addr_strobe_n,
    output logic local_ctl_oe_n,
    // Arbitration.
    input wire logic local_bus_grant,
    output logic local_bus_request_n,
    output logic local_bus_request_oe_n,
    output logic grant_acknowledge_n,
    output logic grant_acknowledge_oe_n,
    // Interrupts.
    input wire logic local_irq_in_n,
    output logic pci_intb_n
);

    typedef struct packed {
        plebr_state_e state;
        logic [3:0] cnt;
        logic pclk_prev;
        logic write;
        logic [WADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] be_n;
        logic ack;
        logic miss;
        logic [DATA_W-1:0] rdata;
        logic clk_out;
        logic [DATA_W-1:0] ad_out;
        logic ad_oe_n;
        logic [3:0] lane_n;
        logic ds_n;
        logic rw;
        logic as_n;
        logic ctl_oe_n;
        logic req_n;
        logic req_oe_n;
        logic gack_n;
        logic gack_oe_n;
        logic intb_n;
        logic clk_oe_n;
        logic [1:0] settle;
    } plebr_regs_s;

    localparam plebr_regs_s REGS_RESET = '{
        state: ST_IDLE,
        cnt: 4'h0,
        pclk_prev: 1'h0,
        write: 1'h0,
        waddr: '0,
        wdata: DATA_RESET,
        be_n: LANES_IDLE,
        ack: 1'h0,
        miss: 1'h0,
        rdata: DATA_RESET,
        clk_out: 1'h1,
        ad_out: DATA_RESET,
        ad_oe_n: 1'h1,
        lane_n: LANES_IDLE,
        ds_n: 1'h1,
        rw: 1'h1,
        as_n: 1'h1,
        ctl_oe_n: 1'h1,
        req_n: 1'h1,
        req_oe_n: 1'h1,
        gack_n: 1'h1,
        gack_oe_n: 1'h1,
        intb_n: 1'h1,
        clk_oe_n: 1'h0,
        settle: 2'h0
    };

    plebr_regs_s r;
    plebr_regs_s next_r;
    logic [SYNC_W-1:0] sync_out;
    logic pclk_s;
    logic grant_s;
    logic irq_n_s;
    logic [DATA_W-1:0] ad_in_s;
    logic tick;
    logic hit;

    // True when the data strobe with direction line style is selected.
    // The style is read in ST_GACK, ST_ADDR and ST_DATA, so it must not change mid-access.
    function automatic logic dstrobe_style(input logic mode);
        return mode == MODE_DSTROBE;
    endfunction

    // Address phase word: the PCI word address low, zeros above it.
    // The window decode has already used the upper bits, so peripherals
    // only ever see the word offset inside the window.
    function automatic logic [31:0] addr_phase_word(
        input logic [WADDR_W-1:0] waddr
    );
        return {ADDR_ZERO_FILL, waddr};
    endfunction

    // True on the last PCI clock period of the data phase.
    function automatic logic last_period(input logic [3:0] cnt);
        return cnt <= 4'h1;
    endfunction

    // All pin inputs cross through two flip-flops first.
    // Read data therefore arrive two clocks late, which is harmless
    // because the read strobe stands for whole PCI clock periods.
    plebr_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din({pci_clk, local_bus_grant, local_irq_in_n,
              local_addr_data_in}),
        .dout(sync_out)
    );

    // Split the synchronised group and find PCI clock rising edges.
    // Each sequencer step from ST_REQ to ST_REL waits for such an edge, so the local side
    // moves once per PCI clock period however fast the system clock is.
    assign pclk_s = sync_out[SYNC_W-1];
    assign grant_s = sync_out[SYNC_W-2];
    assign irq_n_s = sync_out[SYNC_W-3];
    assign ad_in_s = sync_out[DATA_W-1:0];
    assign tick = pclk_s & ~r.pclk_prev;
    assign hit = (req_addr[BASE_MSB:BASE_LSB] == window_base);

    // Next-state logic for the whole sequencer.
    always_comb begin
        next_r = r;
        next_r.pclk_prev = pclk_s;
        next_r.ack = 1'h0;
        next_r.miss = 1'h0;
        next_r.clk_out = ~pclk_s;
        next_r.clk_oe_n = 1'h0;
        next_r.intb_n = irq_n_s;
        // Both synchroniser stages leave reset low, which would read as an
        // active local interrupt; keep the PCI pin quiet until the stages
        // carry real pin levels.
        if (r.settle != SYNC_SETTLE) begin
            next_r.settle = r.settle + 2'h1;
            next_r.intb_n = 1'h1;
        end
        case (r.state)
            ST_IDLE: begin
                // Direction rests at read so no write can be seen while
                // the bridge waits for a request that hits the window.
                next_r.rw = 1'h1;
                if (req_valid && !r.miss) begin
                    if (hit) begin
                        next_r.write = req_write;
                        next_r.waddr = req_addr[WADDR_MSB:WADDR_LSB];
                        next_r.wdata = req_wdata;
                        next_r.be_n = req_be_n;
                        next_r.req_n = 1'h0;
                        next_r.req_oe_n = 1'h0;
                        next_r.state = ST_REQ;
                    end else begin
                        next_r.miss = 1'h1;
                    end
                end
            end
            ST_REQ: begin
                // Wait for the arbiter before touching the bus.
                // A grant held high for good is taken at the next
                // PCI clock edge, a handshake grant at the first PCI clock edge after it comes.
                if (tick && grant_s) begin
                    next_r.gack_n = 1'h0;
                    next_r.gack_oe_n = 1'h0;
                    next_r.state = ST_GACK;
                end
            end
            ST_GACK: begin
                // Address phase: word address low, zeros above.
                // Lanes stay high here so no peripheral mistakes the
                // address for data.
                if (tick) begin
                    next_r.ad_out = addr_phase_word(r.waddr);
                    next_r.ad_oe_n = 1'h0;
                    next_r.ctl_oe_n = 1'h0;
                    next_r.as_n = 1'h0;
                    next_r.lane_n = LANES_IDLE;
                    next_r.ds_n = 1'h1;
                    if (dstrobe_style(strobe_mode)) begin
                        next_r.rw = ~r.write;
                    end else begin
                        next_r.rw = 1'h1;
                    end
                    next_r.state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                // Data phase: lanes, data and strobes.
                // On a read the data lines float so the selected
                // peripherals can drive them.
                if (tick) begin
                    next_r.lane_n = r.be_n;
                    if (r.write) begin
                        next_r.ad_out = r.wdata;
                        next_r.ad_oe_n = 1'h0;
                    end else begin
                        next_r.ad_oe_n = 1'h1;
                    end
                    if (dstrobe_style(strobe_mode)) begin
                        next_r.ds_n = 1'h0;
                        next_r.rw = ~r.write;
                    end else if (r.write) begin
                        next_r.ds_n = 1'h1;
                        next_r.rw = 1'h0;
                    end else begin
                        next_r.ds_n = 1'h0;
                        next_r.rw = 1'h1;
                    end
                    next_r.cnt = DATA_TICKS;
                    next_r.state = ST_DATA;
                end
            end
            ST_DATA: begin
                // Hold strobes; on the last period end the access.
                // Read data are taken as the strobe rises, after they
                // have stood on the synchronised lines for a full period.
                if (tick) begin
                    if (!last_period(r.cnt)) begin
                        next_r.cnt = r.cnt - 4'h1;
                    end else begin
                        next_r.ds_n = 1'h1;
                        if (!dstrobe_style(strobe_mode)) begin
                            next_r.rw = 1'h1;
                        end
                        next_r.as_n = 1'h1;
                        next_r.lane_n = LANES_IDLE;
                        next_r.ad_oe_n = 1'h1;
                        next_r.rdata = ad_in_s;
                        next_r.ack = 1'h1;
                        next_r.gack_n = 1'h1;
                        next_r.req_n = 1'h1;
                        next_r.state = ST_REL;
                    end
                end
            end
            ST_REL: begin
                // Deasserted levels have stood one PCI clock period; release lines.
                // Floating any earlier would leave the pullups to make the
                // rising edge, too slow for the peripherals and arbiter.
                if (tick) begin
                    next_r.ctl_oe_n = 1'h1;
                    next_r.req_oe_n = 1'h1;
                    next_r.gack_oe_n = 1'h1;
                    next_r.state = ST_FLOAT;
                end
            end
            ST_FLOAT: begin
                // One idle cycle lets the target drop its request.
                // Without it the old request would start a second access.
                next_r.state = ST_IDLE;
            end
            default: begin
                // An illegal state code returns the bridge to its reset state.
                next_r = REGS_RESET;
            end
        endcase
    end

    // State register, cleared by reset.
    // Reset floats every local line except the local bus clock, which stays driven, and drops any access in flight.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Outputs come straight from the state register.
    // No output passes through logic, so pins never glitch between
    // clock edges.
    assign req_ack = r.ack;
    assign req_miss = r.miss;
    assign req_rdata = r.rdata;
    assign local_bus_clock_out = r.clk_out;
    assign local_bus_clock_oe_n = r.clk_oe_n;
    assign local_addr_data_out = r.ad_out;
    assign local_addr_data_oe_n = r.ad_oe_n;
    assign local_lane_select_n = r.lane_n;
    assign local_data_strobe_n = r.ds_n;
    assign local_rw_strobe = r.rw;
    assign local_addr_strobe_n = r.as_n;
    assign local_ctl_oe_n = r.ctl_oe_n;
    assign local_bus_request_n = r.req_n;
    assign local_bus_request_oe_n = r.req_oe_n;
    assign grant_acknowledge_n = r.gack_n;
    assign grant_acknowledge_oe_n = r.gack_oe_n;
    assign pci_intb_n = r.intb_n;

endmodule

// ### plebr_bridge_chk.sv
// Port checker for the local bus bridge, bound to the bridge.
`timescale 1ns/10ps
module plebr_bridge_chk
    import plebr_pkg::*;
#(parameter int DATA_W = 32) (
    // Clock, reset, mode and request side.
    input wire logic clk, resetn, pci_clk, strobe_mode,
    input wire logic req_valid, req_write, req_miss,
    input wire logic [31:0] req_addr,
    input wire logic [3:0] req_be_n,
    input wire logic [DATA_W-1:0] req_wdata, local_addr_data_out,
    // Local side.
    input wire logic [3:0] local_lane_select_n,
    input wire logic local_bus_clock_out, local_data_strobe_n,
    input wire logic local_rw_strobe, local_addr_strobe_n, local_ctl_oe_n,
    input wire logic local_bus_request_n, grant_acknowledge_n,
    input wire logic local_addr_data_oe_n,
    input wire logic local_irq_in_n, pci_intb_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    clk_inverse_a: assert property (
        $rose(pci_clk) |-> ##[1:5] !local_bus_clock_out)
        else $error("local clock not inverted");
    addr_phase_a: assert property (
        $fell(local_addr_strobe_n) |-> local_addr_data_out ==
        {ADDR_ZERO_FILL, req_addr[WADDR_MSB:WADDR_LSB]})
        else $error("bad address phase");
    data_pass_a: assert property (
        local_lane_select_n != LANES_IDLE && req_write && req_valid
        |-> local_addr_data_out == req_wdata)
        else $error("write data altered");
    bus_turn_a: assert property (
        local_lane_select_n != LANES_IDLE
        |-> local_addr_data_oe_n == !req_write)
        else $error("data bus driven the wrong way");
    lanes_copy_a: assert property (
        local_lane_select_n != LANES_IDLE
        |-> local_lane_select_n == req_be_n && !local_addr_strobe_n)
        else $error("lane selects differ from enables");
    lanes_idle_a: assert property (
        local_addr_strobe_n |-> local_lane_select_n == LANES_IDLE)
        else $error("lane select outside data phase");
    dir_level_a: assert property (
        strobe_mode && !local_data_strobe_n
        |-> local_rw_strobe == !req_write)
        else $error("direction level wrong");
    rd_quiet_a: assert property (
        !strobe_mode && req_write && !grant_acknowledge_n
        |-> local_data_strobe_n)
        else $error("read strobe during write");
    strobe_hold_a: assert property (
        $fell(local_data_strobe_n)
        |-> (!local_data_strobe_n && !local_addr_strobe_n)[*8])
        else $error("strobe dropped early");
    owned_a: assert property (
        !local_data_strobe_n || !local_addr_strobe_n ||
        (!strobe_mode && !local_rw_strobe)
        |-> !grant_acknowledge_n && !local_bus_request_n)
        else $error("strobe without bus ownership");
    float_high_a: assert property (
        $rose(local_ctl_oe_n)
        |-> $past(local_addr_strobe_n) && $past(local_data_strobe_n))
        else $error("floated without driving high");
    miss_quiet_a: assert property (
        req_miss |-> local_bus_request_n && grant_acknowledge_n)
        else $error("local cycle on a miss");
    irq_fwd_a: assert property (
        $fell(local_irq_in_n) |-> ##[1:4] !pci_intb_n)
        else $error("interrupt not forwarded");
endmodule
bind plebr_bridge plebr_bridge_chk #(.DATA_W(DATA_W)) u_chk (
    .clk(clk), .resetn(resetn), .pci_clk(pci_clk), .strobe_mode(strobe_mode),
    .req_valid(req_valid), .req_write(req_write), .req_miss(req_miss),
    .req_addr(req_addr), .req_be_n(req_be_n), .req_wdata(req_wdata),
    .local_addr_data_out(local_addr_data_out),
    .local_addr_data_oe_n(local_addr_data_oe_n),
    .local_lane_select_n(local_lane_select_n),
    .local_bus_clock_out(local_bus_clock_out),
    .local_data_strobe_n(local_data_strobe_n),
    .local_rw_strobe(local_rw_strobe),
    .local_addr_strobe_n(local_addr_strobe_n),
    .local_ctl_oe_n(local_ctl_oe_n),
    .local_bus_request_n(local_bus_request_n),
    .grant_acknowledge_n(grant_acknowledge_n),
    .local_irq_in_n(local_irq_in_n), .pci_intb_n(pci_intb_n)
);

// ### plebr_peer.sv
// Behavioural bank of byte-wide peripherals and a local bus arbiter.
`timescale 1ns/10ps
module plebr_peer (
    // Clock and arbiter style.
    input wire logic clk,
    input wire logic hold_grant,
    // Bridge local side.
    input wire logic strobe_mode, local_data_strobe_n, local_rw_strobe,
    input wire logic local_addr_strobe_n, local_bus_request_n,
    input wire logic [3:0] local_lane_select_n,
    input wire logic [31:0] local_addr_data_out,
    output logic [31:0] local_addr_data_in,
    output logic local_bus_grant
);
    logic [31:0] mem [16];
    logic [31:0] last_rd, prv_data;
    logic [3:0] adr, prv_lanes, gcnt;
    logic prv_wr, wr_act, rd_act;
    // Strobe meaning follows the selected style.
    assign wr_act = strobe_mode ? !local_data_strobe_n && !local_rw_strobe
                                : !local_rw_strobe;
    assign rd_act = strobe_mode ? !local_data_strobe_n && local_rw_strobe
                                : !local_data_strobe_n;
    // Data only while read strobe is low, else the inverse of the last word.
    assign local_addr_data_in = rd_act ? mem[adr] : ~last_rd;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 32'h0;
        {last_rd, adr, gcnt, prv_wr, local_bus_grant} = '0;
    end
    // Latch the address, commit writes at strobe end, run the arbiter.
    always @(posedge clk) begin
        if (!local_addr_strobe_n && local_lane_select_n == 4'hf)
            adr <= local_addr_data_out[3:0];
        if (rd_act)
            last_rd <= mem[adr];
        for (int b = 0; b < 4; b++)
            if (prv_wr && !wr_act && !prv_lanes[b])
                mem[adr][8*b +: 8] <= prv_data[8*b +: 8];
        prv_wr <= wr_act;
        prv_lanes <= local_lane_select_n;
        prv_data <= local_addr_data_out;
        gcnt <= local_bus_request_n ? 4'h0 : gcnt + {3'h0, gcnt != 4'hf};
        local_bus_grant <= hold_grant || gcnt == 4'hf;
    end
endmodule

// ### plebr_pkg.sv
// Shared constants and types for the local expansion bus bridge.
package plebr_pkg;

    // Upper PCI address bits compared with the window base.
    localparam int BASE_MSB = 31;
    localparam int BASE_LSB = 20;
    localparam int BASE_W = BASE_MSB - BASE_LSB + 1;

    // Word address field taken from the PCI address.
    localparam int WADDR_MSB = 19;
    localparam int WADDR_LSB = 2;
    localparam int WADDR_W = WADDR_MSB - WADDR_LSB + 1;

    // Zero fill for the upper local lines during the address phase.
    localparam int ZERO_W = 32 - WADDR_W;
    localparam logic [ZERO_W-1:0] ADDR_ZERO_FILL = 14'h0;

    // Data phase length in PCI clock periods, at least one.
    localparam logic [3:0] DATA_TICKS = 4'h2;

    // Reset levels of the local bus controls.
    localparam logic [3:0] LANES_IDLE = 4'hf;
    localparam logic [31:0] DATA_RESET = 32'h0;

    // Width of the group of inputs that cross into the clock domain.
    localparam int SYNC_W = 35;

    // Clock edges after reset before the synchronised pins are real.
    localparam logic [1:0] SYNC_SETTLE = 2'h2;

    // Mode select values.
    localparam logic MODE_SEPARATE = 1'h0;
    localparam logic MODE_DSTROBE = 1'h1;

    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_REQ = 7'h02,
        ST_GACK = 7'h04,
        ST_ADDR = 7'h08,
        ST_DATA = 7'h10,
        ST_REL = 7'h20,
        ST_FLOAT = 7'h40
    } plebr_state_e;

endpackage

// ### plebr_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/10ps
module plebr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Asynchronous inputs and their synchronised copy.
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// ### tb_top.sv
// Self-checking bench for the local bus bridge.
`timescale 1ns/10ps
module tb_top import plebr_pkg::*;;
    logic clk, resetn, pci_clk, strobe_mode, hold_grant, req_valid, req_write;
    logic irq_n, req_ack, req_miss, grant, intb_n, miss;
    logic ds_n, rw, as_n, ctl_oe_n, breq_n, gack_n;
    logic [BASE_W-1:0] window_base;
    logic [31:0] req_addr, req_wdata, req_rdata, ad_in, ad_out;
    logic [3:0] req_be_n, lanes;
    int num_errors, n_compared;
    plebr_bridge u_plebr_bridge (.clk(clk), .resetn(resetn), .pci_clk(pci_clk),
        .window_base(window_base), .strobe_mode(strobe_mode),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_be_n(req_be_n), .req_wdata(req_wdata), .req_ack(req_ack),
        .req_miss(req_miss), .req_rdata(req_rdata), .local_bus_clock_out(),
        .local_bus_clock_oe_n(), .local_addr_data_in(ad_in),
        .local_addr_data_out(ad_out), .local_addr_data_oe_n(),
        .local_lane_select_n(lanes), .local_data_strobe_n(ds_n),
        .local_rw_strobe(rw), .local_addr_strobe_n(as_n),
        .local_ctl_oe_n(ctl_oe_n), .local_bus_grant(grant),
        .local_bus_request_n(breq_n), .local_bus_request_oe_n(),
        .grant_acknowledge_n(gack_n), .grant_acknowledge_oe_n(),
        .local_irq_in_n(irq_n), .pci_intb_n(intb_n));
    plebr_peer u_plebr_peer (.clk(clk), .hold_grant(hold_grant),
        .strobe_mode(strobe_mode), .local_data_strobe_n(ds_n),
        .local_rw_strobe(rw), .local_addr_strobe_n(as_n),
        .local_bus_request_n(breq_n), .local_lane_select_n(lanes),
        .local_addr_data_out(ad_out), .local_addr_data_in(ad_in),
        .local_bus_grant(grant));
    // System clock at 25 ns and PCI clock at 200 ns, started 7 ns late.
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        pci_clk = 0;
        #7;
        forever #100 pci_clk = ~pci_clk;
    end
    // Compare a seen value with its expectation and count it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Wait one cycle of a bounded wait; running out ends the run.
    task automatic wait_step(inout int n);
        @(negedge clk);
        n++;
        if (n >= 400) begin
            num_errors++;
            complete_run();
        end
    endtask
    // One word access, held until answered, then the required gap.
    task automatic access(input logic wr, input logic [31:0] a,
                          input logic [3:0] be, input logic [31:0] d);
        int n;
        n = 0;
        req_valid = 1;
        {req_write, req_addr, req_be_n, req_wdata} = {wr, a, be, d};
        @(negedge clk);
        while (req_ack !== 1'b1 && req_miss !== 1'b1)
            wait_step(n);
        miss = req_miss;
        req_valid = 0;
        repeat (2) @(negedge clk);
    endtask
    // Separate strobes with the grant held: write then read back.
    task automatic t_separate();
        {strobe_mode, hold_grant} = {MODE_SEPARATE, 1'b1};
        access(1, 32'h5a300054, 4'h0, 32'hc3a51e70);
        access(0, 32'h5a300054, 4'h0, 32'h0);
        check(req_rdata, 32'hc3a51e70);
        check({31'h0, miss}, 32'h0);
    endtask
    // Data strobe with a slow arbiter: full and partial lane writes.
    task automatic t_dstrobe();
        {strobe_mode, hold_grant} = {MODE_DSTROBE, 1'b0};
        access(1, 32'h5a300058, 4'h0, 32'h11223344);
        access(1, 32'h5a300058, 4'hc, 32'haabbccdd);
        access(0, 32'h5a300058, 4'h0, 32'h0);
        check(req_rdata, 32'h1122ccdd);
        access(0, 32'h5a300054, 4'h0, 32'h0);
        check(req_rdata, 32'hc3a51e70);
    endtask
    // Address outside the window is refused with no local cycle.
    task automatic t_miss();
        access(0, 32'h5a400054, 4'h0, 32'h0);
        check({31'h0, miss}, 32'h1);
    endtask
    // Local interrupt reaches the PCI pin and clears again.
    task automatic t_irq();
        irq_n = 0;
        repeat (5) @(negedge clk);
        check({31'h0, intb_n}, 32'h0);
        irq_n = 1;
        repeat (5) @(negedge clk);
        check({31'h0, intb_n}, 32'h1);
    endtask
    // Reset during an address phase, then the bridge works again.
    task automatic t_reset();
        int n;
        n = 0;
        req_valid = 1;
        {req_write, req_addr, req_be_n} = {1'b1, 32'h5a30005c, 4'h0};
        while (ctl_oe_n !== 1'b0)
            wait_step(n);
        resetn = 0;
        req_valid = 0;
        @(negedge clk);
        check({25'h0, ctl_oe_n, breq_n, gack_n, lanes}, 32'h7f);
        check({30'h0, req_ack, intb_n}, 32'h1);
        repeat (8) @(negedge clk);
        resetn = 1;
        @(negedge clk);
        check({31'h0, intb_n}, 32'h1);
        repeat (2) @(negedge clk);
        access(0, 32'h5a300058, 4'h0, 32'h0);
        check(req_rdata, 32'h1122ccdd);
    endtask
    initial begin
        {resetn, strobe_mode, hold_grant, req_valid, req_write} = 5'h04;
        {req_addr, req_wdata, req_be_n, irq_n} = {64'h0, 4'hf, 1'b1};
        {window_base, num_errors, n_compared} = {12'h5a3, 64'h0};
        repeat (8) @(negedge clk);
        resetn = 1;
        repeat (3) @(negedge clk);
        t_separate();
        t_dstrobe();
        t_miss();
        t_irq();
        t_reset();
        complete_run();
    end
endmodule
